/* File: core/cpu_core_regs_addressing.v */
// cpu working registers, operand fetch and addressing mode execution
`timescale 1ns/1ns
`include "cpu_core_regs.vh"
module cpu_core_regs_addressing (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_nrst,
    // decoded instruction request
    input  wire        i_instr_valid,
    input  wire [3:0]  i_addr_mode,
    input  wire [2:0]  i_alu_op,
    input  wire [1:0]  i_target,
    input  wire        i_use_reg_space,
    input  wire        i_upd_flags,
    input  wire [2:0]  i_stack_op,
    input  wire        i_pc_load,
    input  wire [15:0] i_pc_target,
    // program memory
    output wire [15:0] o_prog_addr,
    input  wire [7:0]  i_prog_data,
    // data ram / register space
    output reg  [7:0]  o_mem_addr,
    output reg         o_mem_rd,
    output reg         o_mem_wr,
    output reg         o_mem_reg_space,
    output reg  [7:0]  o_mem_wdata,
    input  wire [7:0]  i_mem_rdata,
    // supervisor entry/exit and interrupt request
    input  wire        i_super_enter,
    input  wire        i_super_exit,
    input  wire        i_irq_req,
    // status
    output wire        o_busy,
    output wire        o_irq_take,
    output wire        o_bank_select_bit,
    output wire [7:0]  o_program_counter_high,
    output wire [7:0]  o_program_counter_low,
    output wire [7:0]  o_acc,
    output wire [7:0]  o_index,
    output wire [7:0]  o_stack_pointer_reg,
    output wire [7:0]  o_status_flags
);
    // ****************************************
    // states
    // ****************************************
    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_OP1  = 6'b000010;
    localparam [5:0] ST_OP2  = 6'b000100;
    localparam [5:0] ST_RD   = 6'b001000;
    localparam [5:0] ST_EXEC = 6'b010000;
    localparam [5:0] ST_WR   = 6'b100000;

    // instruction length from addressing mode
    function [1:0] instr_len;
        input [3:0] mode;
        begin
            case (mode)
                `AM_NONE:                          instr_len = 2'd1;
                `AM_DST_DIR_IMM, `AM_DST_IDX_IMM:  instr_len = 2'd3;
                default:                           instr_len = 2'd2;
            endcase
        end
    endfunction

    // does the mode add the index register
    function is_indexed;
        input [3:0] mode;
        begin
            is_indexed = (mode == `AM_SRC_IDX) || (mode == `AM_DST_IDX) || (mode == `AM_DST_IDX_IMM);
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg [5:0]  state_ff;
    reg [15:0] program_counter_reg_ff;
    reg [7:0]  acc_ff;
    reg [7:0]  index_ff;
    reg [7:0]  stack_pointer_reg_ff;
    reg [7:0]  flags_ff;
    reg [7:0]  op1_ff;
    reg [7:0]  op2_ff;
    reg [7:0]  mem_data_ff;
    reg [3:0]  mode_ff;
    reg [2:0]  alu_op_ff;
    reg [1:0]  target_ff;
    reg        reg_space_ff;
    reg        upd_flags_ff;
    reg [2:0]  stack_op_ff;
    reg        pc_load_ff;
    reg [15:0] pc_target_ff;
    reg [1:0]  len_ff;

    // ****************************************
    // alu operand selection
    // ****************************************
    reg  [7:0] alu_a;
    reg  [7:0] alu_b;
    wire [7:0] alu_res;
    wire       alu_carry;
    wire       alu_zero;
    wire       src_mode;
    wire [7:0] tgt_val;
    wire [7:0] eff_addr;

    assign src_mode = (mode_ff == `AM_SRC_IMM) || (mode_ff == `AM_SRC_DIR) || (mode_ff == `AM_SRC_IDX);
    assign tgt_val  = (target_ff == `TGT_X) ? index_ff :
                      (target_ff == `TGT_SP) ? stack_pointer_reg_ff :
                      (target_ff == `TGT_F) ? flags_ff : acc_ff;
    // indexed address wraps inside the 256-byte space
    // operand plus index
    assign eff_addr = is_indexed(mode_ff) ? (op1_ff + index_ff) : op1_ff;

    always @* begin
        alu_a = tgt_val;
        alu_b = mem_data_ff;
        case (mode_ff)
            `AM_SRC_IMM: begin
                alu_a = tgt_val;
                alu_b = op1_ff;
            end
            `AM_SRC_DIR, `AM_SRC_IDX: alu_b = mem_data_ff;
            `AM_DST_DIR: begin
                alu_a = mem_data_ff;
                alu_b = tgt_val;
            end
            `AM_DST_IDX: begin
                alu_a = mem_data_ff;
                alu_b = acc_ff;
            end
            `AM_DST_DIR_IMM, `AM_DST_IDX_IMM: begin
                alu_a = mem_data_ff;
                alu_b = op2_ff;
            end
            default: alu_b = mem_data_ff;
        endcase
    end

    alu8 u_alu (
        .i_op    (alu_op_ff),
        .i_a     (alu_a),
        .i_b     (alu_b),
        .o_res   (alu_res),
        .o_carry (alu_carry),
        .o_zero  (alu_zero)
    );

    wire needs_read = (mode_ff != `AM_SRC_IMM) && (mode_ff != `AM_NONE) &&
                      (src_mode || (alu_op_ff != `OP_MOV));
    wire dst_mode   = !src_mode && (mode_ff != `AM_NONE);
    // flags register reachable only at its explicit address
    // flags read at F7
    wire [7:0] rd_data = (reg_space_ff && eff_addr == `FLAGS_ADDR) ? flags_ff : i_mem_rdata;

    // ****************************************
    // memory bus drive
    // ****************************************
    always @* begin
        o_mem_addr      = eff_addr;
        o_mem_rd        = (state_ff == ST_RD);
        o_mem_wr        = (state_ff == ST_WR);
        o_mem_reg_space = reg_space_ff;
        o_mem_wdata     = mem_data_ff;
    end

    // ****************************************
    // sequencer and register update
    // ****************************************
    reg [7:0] nxt_flags;
    always @* begin
        nxt_flags = flags_ff;
        if (upd_flags_ff) begin
            nxt_flags[`FLG_CARRY] = alu_carry;
            nxt_flags[`FLG_ZERO]  = alu_zero;
        end
        if (src_mode && target_ff == `TGT_F) begin
            nxt_flags = (flags_ff & ~`FLAGS_WMASK) | (alu_res & `FLAGS_WMASK);
        end
        nxt_flags[`FLG_SUPER] = flags_ff[`FLG_SUPER];
        nxt_flags[7:5] = 3'b000;
    end

    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff               <= ST_IDLE;
            program_counter_reg_ff <= `PC_RESET;
            acc_ff                 <= 8'h00;
            index_ff               <= 8'h00;
            stack_pointer_reg_ff   <= 8'h00;
            flags_ff               <= `FLAGS_RESET;
            op1_ff                 <= 8'h00;
            op2_ff                 <= 8'h00;
            mem_data_ff            <= 8'h00;
            mode_ff                <= `AM_NONE;
            alu_op_ff              <= `OP_MOV;
            target_ff              <= `TGT_A;
            reg_space_ff           <= 1'b0;
            upd_flags_ff           <= 1'b0;
            stack_op_ff            <= `SK_NONE;
            pc_load_ff             <= 1'b0;
            pc_target_ff           <= 16'h0000;
            len_ff                 <= 2'd1;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (i_instr_valid) begin
                        mode_ff      <= i_addr_mode;
                        alu_op_ff    <= i_alu_op;
                        target_ff    <= i_target;
                        reg_space_ff <= i_use_reg_space;
                        upd_flags_ff <= i_upd_flags;
                        stack_op_ff  <= i_stack_op;
                        pc_load_ff   <= i_pc_load;
                        pc_target_ff <= i_pc_target;
                        len_ff       <= instr_len(i_addr_mode);
                        state_ff     <= (i_addr_mode == `AM_NONE) ? ST_EXEC : ST_OP1;
                    end
                end
                ST_OP1: begin
                    op1_ff   <= i_prog_data;
                    state_ff <= (len_ff == 2'd3) ? ST_OP2 : ST_RD;
                end
                ST_OP2: begin
                    op2_ff   <= i_prog_data;
                    state_ff <= ST_RD;
                end
                ST_RD: begin
                    // reads harmless when not needed; data replaced by zero
                    mem_data_ff <= needs_read ? rd_data : 8'h00;
                    state_ff    <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (src_mode) begin
                        if (target_ff == `TGT_A) begin
                            acc_ff <= alu_res;
                        end
                        if (target_ff == `TGT_X) begin
                            index_ff <= alu_res;
                        end
                        if (target_ff == `TGT_SP) begin
                            stack_pointer_reg_ff <= alu_res;
                        end
                    end
                    flags_ff <= nxt_flags;
                    case (stack_op_ff)
                        `SK_PUSH: stack_pointer_reg_ff <= stack_pointer_reg_ff + 8'h01;
                        `SK_POP:  stack_pointer_reg_ff <= stack_pointer_reg_ff - 8'h01;
                        `SK_CALL: stack_pointer_reg_ff <= stack_pointer_reg_ff + 8'h02;
                        `SK_RET:  stack_pointer_reg_ff <= stack_pointer_reg_ff - 8'h02;
                        `SK_ADD:  stack_pointer_reg_ff <= stack_pointer_reg_ff + op1_ff;
                        `SK_SWAP: stack_pointer_reg_ff <= acc_ff;
                        default:  stack_pointer_reg_ff <= stack_pointer_reg_ff;
                    endcase
                    if (stack_op_ff == `SK_SWAP) begin
                        acc_ff <= stack_pointer_reg_ff;
                    end
                    if (pc_load_ff) begin
                        program_counter_reg_ff <= pc_target_ff;
                    end else begin
                        program_counter_reg_ff <= program_counter_reg_ff + {14'h0000, len_ff};
                    end
                    mem_data_ff <= alu_res;
                    state_ff <= dst_mode ? ST_WR : ST_IDLE;
                end
                ST_WR: begin
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
            // placed last so the pins win over any flags write
            // supervisor set by hardware only
            if (i_super_enter) begin
                flags_ff[`FLG_SUPER] <= 1'b1;
            end else if (i_super_exit) begin
                flags_ff[`FLG_SUPER] <= 1'b0;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // operand bytes follow the opcode; the fetch address tracks the sequencer
    // full program address
    assign o_prog_addr = (state_ff == ST_OP1) ? program_counter_reg_ff + 16'h0001 :
                         (state_ff == ST_OP2) ? program_counter_reg_ff + 16'h0002 :
                         program_counter_reg_ff;
    assign o_busy = (state_ff != ST_IDLE);
    assign o_irq_take = i_irq_req & flags_ff[`FLG_GIE];
    assign o_bank_select_bit = flags_ff[`FLG_BANK];
    assign o_program_counter_high = program_counter_reg_ff[15:8];
    assign o_program_counter_low  = program_counter_reg_ff[7:0];
    assign o_acc               = acc_ff;
    assign o_index             = index_ff;
    assign o_stack_pointer_reg = stack_pointer_reg_ff;
    assign o_status_flags      = flags_ff;
endmodule

/* File: pkg/cpu_core_regs.vh */
// constants for the cpu register set and addressing modes
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH

// register-space address of the flags register
`define FLAGS_ADDR        8'hF7
// flags field positions
`define FLG_GIE           0
`define FLG_ZERO          1
`define FLG_CARRY         2
`define FLG_SUPER         3
`define FLG_BANK          4
// flags reset value and writable mask
`define FLAGS_RESET       8'h02
`define FLAGS_WMASK       8'h17
// addressing mode codes
`define AM_NONE           4'h0
`define AM_SRC_IMM        4'h1
`define AM_SRC_DIR        4'h2
`define AM_SRC_IDX        4'h3
`define AM_DST_DIR        4'h4
`define AM_DST_IDX        4'h5
`define AM_DST_DIR_IMM    4'h6
`define AM_DST_IDX_IMM    4'h7
// target register select
`define TGT_A             2'h0
`define TGT_X             2'h1
`define TGT_SP            2'h2
`define TGT_F             2'h3
// alu operation codes
`define OP_MOV            3'h0
`define OP_ADD            3'h1
`define OP_SUB            3'h2
`define OP_AND            3'h3
`define OP_OR             3'h4
`define OP_XOR            3'h5
// stack operation codes and program counter reset value
`define SK_NONE           3'h0
`define SK_PUSH           3'h1
`define SK_POP            3'h2
`define SK_CALL           3'h3
`define SK_RET            3'h4
`define SK_ADD            3'h5
`define SK_SWAP           3'h6
`define PC_RESET          16'h0000

`endif

/* File: core/alu8.v */
// 8-bit alu with carry and zero outputs
`timescale 1ns/1ns
`include "cpu_core_regs.vh"
module alu8 (
    // operation and operands
    input  wire [2:0] i_op,
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    // results
    output reg  [7:0] o_res,
    output reg        o_carry,
    output wire       o_zero
);
    reg [8:0] wide;
    always @* begin
        wide = 9'h000;
        case (i_op)
            `OP_MOV: wide = {1'b0, i_b};
            `OP_ADD: wide = {1'b0, i_a} + {1'b0, i_b};
            `OP_SUB: wide = {1'b0, i_a} - {1'b0, i_b};
            `OP_AND: wide = {1'b0, i_a & i_b};
            `OP_OR:  wide = {1'b0, i_a | i_b};
            `OP_XOR: wide = {1'b0, i_a ^ i_b};
            default: wide = {1'b0, i_b};
        endcase
        o_res   = wide[7:0];
        o_carry = wide[8];
    end
    assign o_zero = (o_res == 8'h00);
endmodule

/* File: tb/cpu_core_regs_addressing_asserts.sv */
// assertion checker for the cpu register set and addressing modes
`timescale 1ns/1ns
module cpu_core_regs_addressing_asserts (
    // clock and reset
    input wire        i_core_clk,
    input wire        i_nrst,
    // request side
    input wire        i_instr_valid,
    input wire        i_super_enter,
    input wire        i_super_exit,
    input wire        i_irq_req,
    // outputs watched
    input wire [15:0] o_prog_addr,
    input wire        o_mem_rd,
    input wire        o_mem_wr,
    input wire        o_busy,
    input wire        o_irq_take,
    input wire        o_bank_select_bit,
    input wire [7:0]  o_program_counter_high,
    input wire [7:0]  o_program_counter_low,
    input wire [7:0]  o_acc,
    input wire [7:0]  o_status_flags
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    chk_busy_start: assert property (!o_busy && i_instr_valid |=> o_busy)
        else $error("busy did not rise after an accepted request");
    // longest walk is six cycles, with write-back
    chk_busy_bound: assert property (!o_busy && i_instr_valid |-> ##[2:6] !o_busy)
        else $error("instruction did not finish in time");
    chk_rd_pulse: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("read strobe longer than one cycle");
    chk_wr_pulse: assert property (o_mem_wr |=> !o_mem_wr)
        else $error("write strobe longer than one cycle");
    chk_acc_kept: assert property (o_mem_wr |-> $stable(o_acc))
        else $error("accumulator changed by a destination mode");
    chk_reserved_zero: assert property (o_status_flags[7:5] == 3'b000)
        else $error("reserved flag bits not zero");
    chk_irq_gate: assert property (o_irq_take == (i_irq_req & o_status_flags[0]))
        else $error("interrupt not gated by global enable");
    chk_bank_out: assert property (o_bank_select_bit == o_status_flags[4])
        else $error("bank output differs from flag bit");
    chk_super_hold: assert property (!i_super_enter && !i_super_exit |=>
        o_status_flags[3] == $past(o_status_flags[3]))
        else $error("supervisor bit changed without entry or exit");
    chk_pc_fetch: assert property (!o_busy |-> o_prog_addr == {o_program_counter_high,
        o_program_counter_low})
        else $error("idle fetch address differs from program counter");
    chk_pc_idle: assert property (!o_busy && !i_instr_valid |=>
        $stable({o_program_counter_high, o_program_counter_low}))
        else $error("program counter moved while idle");
endmodule

bind cpu_core_regs_addressing cpu_core_regs_addressing_asserts chk (.*);

/* File: tb/cpu_mem_model.sv */
// far-side model: program memory, data ram and register space
`timescale 1ns/1ns
module cpu_mem_model (
    // clock
    input  wire        i_core_clk,
    // program memory
    input  wire [15:0] i_prog_addr,
    output wire [7:0]  o_prog_data,
    // data ram / register space
    input  wire [7:0]  i_mem_addr,
    input  wire        i_mem_rd,
    input  wire        i_mem_wr,
    input  wire        i_mem_reg_space,
    input  wire [7:0]  i_mem_wdata,
    output wire [7:0]  o_mem_rdata
);
    reg [7:0] rom [0:8191];
    reg [7:0] ram [0:255];
    reg [7:0] rgs [0:255];
    reg [7:0] noise_ff = 8'h00;

    // 8 kbyte space, upper pc bits unused
    assign o_prog_data = rom[i_prog_addr[12:0]];
    // outside a read the bus shows a moving pattern, never the last value
    assign o_mem_rdata = !i_mem_rd ? noise_ff : i_mem_reg_space ? rgs[i_mem_addr] : ram[i_mem_addr];

    always @(posedge i_core_clk) begin
        noise_ff <= noise_ff + 8'h5b;
        if (i_mem_wr && i_mem_reg_space)
            rgs[i_mem_addr] <= i_mem_wdata;
        if (i_mem_wr && !i_mem_reg_space)
            ram[i_mem_addr] <= i_mem_wdata;
    end
endmodule

/* File: tb/cpu_core_regs_addressing_test.sv */
// self-checking bench for the cpu register set and addressing modes
`timescale 1ns/1ns
`include "cpu_core_regs.vh"
module cpu_core_regs_addressing_test;
    reg         i_core_clk = 1'b0;
    reg         i_nrst     = 1'b0;
    reg         valid      = 1'b0;
    reg  [3:0]  mode       = 4'h0;
    reg  [2:0]  op         = 3'h0;
    reg  [1:0]  tgt        = 2'h0;
    reg         rs         = 1'b0;
    reg         uf         = 1'b0;
    reg  [2:0]  sk         = 3'h0;
    reg         jmp        = 1'b0;
    reg  [15:0] jdst       = 16'h0000;
    reg         s_en       = 1'b0;
    reg         s_ex       = 1'b0;
    reg         irq        = 1'b0;
    reg  [15:0] epc        = 16'h0000;
    wire [15:0] prog_addr;
    wire [7:0]  prog_data, mem_addr, wdata, rdata, pch, pcl, acc, idx, sp, flags;
    wire        mem_rd, mem_wr, mem_rs, busy, irq_take, bank;
    integer     err_count  = 0;
    integer     n_tests    = 0;
    integer     cyc        = 0;

    always #50 i_core_clk = ~i_core_clk;

    cpu_core_regs_addressing dut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_instr_valid(valid), .i_addr_mode(mode),
        .i_alu_op(op), .i_target(tgt), .i_use_reg_space(rs), .i_upd_flags(uf), .i_stack_op(sk),
        .i_pc_load(jmp), .i_pc_target(jdst), .o_prog_addr(prog_addr), .i_prog_data(prog_data),
        .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_reg_space(mem_rs),
        .o_mem_wdata(wdata), .i_mem_rdata(rdata), .i_super_enter(s_en), .i_super_exit(s_ex),
        .i_irq_req(irq), .o_busy(busy), .o_irq_take(irq_take), .o_bank_select_bit(bank),
        .o_program_counter_high(pch), .o_program_counter_low(pcl), .o_acc(acc), .o_index(idx),
        .o_stack_pointer_reg(sp), .o_status_flags(flags));

    cpu_mem_model mem (
        .i_core_clk(i_core_clk), .i_prog_addr(prog_addr), .o_prog_data(prog_data),
        .i_mem_addr(mem_addr), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .i_mem_reg_space(mem_rs),
        .i_mem_wdata(wdata), .o_mem_rdata(rdata));

    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // whole run needs just over a hundred cycles
    always @(posedge i_core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            close_out;
        end
    end

    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task regs(input [7:0] a, input [7:0] x, input [7:0] s, input [7:0] f);
        begin
            cmp8(acc, a);
            cmp8(idx, x);
            cmp8(sp, s);
            cmp8(flags, f);
            cmp8(pch, epc[15:8]);
            cmp8(pcl, epc[7:0]);
        end
    endtask

    // operands sit after the opcode; qualifiers stay put until the next request
    task run(input [3:0] m, input [2:0] o, input [1:0] t, input r, input u, input [2:0] k,
             input [7:0] b1, input [7:0] b2);
        integer w;
        integer ew;
        begin
            mem.rom[epc[12:0] + 13'h0001] = b1;
            mem.rom[epc[12:0] + 13'h0002] = b2;
            @(negedge i_core_clk);
            mode = m;
            op = o;
            tgt = t;
            rs = r;
            uf = u;
            sk = k;
            valid = 1'b1;
            @(negedge i_core_clk);
            valid = 1'b0;
            w = 0;
            while (busy !== 1'b0 && w < 20) begin
                @(negedge i_core_clk);
                w = w + 1;
            end
            // busy cycles: one per operand byte, a read when there are operands, the execute, a write for destinations
            ew = (m == `AM_NONE) ? 1 : (m < `AM_DST_DIR) ? 3 : (m < `AM_DST_DIR_IMM) ? 4 : 5;
            cmp8(w[7:0], ew[7:0]);
            epc = jmp ? jdst : epc + ((m == `AM_NONE) ? 16'h0001 : (m > `AM_DST_IDX) ? 16'h0003 : 16'h0002);
            jmp = 1'b0;
        end
    endtask

    initial begin
        mem.ram[8'h20] = 8'hb0;
        mem.ram[8'h30] = 8'h01;
        mem.ram[8'h40] = 8'h01;
        mem.rgs[8'h15] = 8'h33;
        // decoy: flags must come from the core, not the bus
        mem.rgs[8'hf7] = 8'haa;
        repeat (4) @(negedge i_core_clk);
        i_nrst = 1'b1;
        irq = 1'b1;
        cmp8({7'h00, busy}, 8'h00);
        regs(8'h00, 8'h00, 8'h00, 8'h02);
        run(`AM_SRC_IMM, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_NONE, 8'h5a, 8'h00);
        run(`AM_SRC_IMM, `OP_MOV, `TGT_X, 1'b0, 1'b0, `SK_NONE, 8'h10, 8'h00);
        regs(8'h5a, 8'h10, 8'h00, 8'h02);
        run(`AM_SRC_DIR, `OP_ADD, `TGT_A, 1'b0, 1'b1, `SK_NONE, 8'h20, 8'h00);
        regs(8'h0a, 8'h10, 8'h00, 8'h04);
        run(`AM_SRC_IDX, `OP_MOV, `TGT_A, 1'b1, 1'b0, `SK_NONE, 8'h05, 8'h00);
        regs(8'h33, 8'h10, 8'h00, 8'h04);
        run(`AM_DST_DIR, `OP_ADD, `TGT_A, 1'b0, 1'b0, `SK_NONE, 8'h30, 8'h00);
        cmp8(mem.ram[8'h30], 8'h34);
        run(`AM_DST_IDX, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_NONE, 8'h02, 8'h00);
        cmp8(mem.ram[8'h12], 8'h33);
        run(`AM_DST_DIR_IMM, `OP_ADD, `TGT_A, 1'b0, 1'b1, `SK_NONE, 8'h40, 8'hff);
        cmp8(mem.ram[8'h40], 8'h00);
        regs(8'h33, 8'h10, 8'h00, 8'h06);
        run(`AM_DST_IDX_IMM, `OP_MOV, `TGT_A, 1'b1, 1'b0, `SK_NONE, 8'h03, 8'h77);
        cmp8(mem.rgs[8'h13], 8'h77);
        run(`AM_SRC_DIR, `OP_MOV, `TGT_A, 1'b1, 1'b0, `SK_NONE, 8'hf7, 8'h00);
        regs(8'h06, 8'h10, 8'h00, 8'h06);
        run(`AM_SRC_IMM, `OP_OR, `TGT_F, 1'b0, 1'b0, `SK_NONE, 8'hff, 8'h00);
        regs(8'h06, 8'h10, 8'h00, 8'h17);
        cmp8({7'h00, bank}, 8'h01);
        cmp8({7'h00, irq_take}, 8'h01);
        @(negedge i_core_clk) s_en = 1'b1;
        @(negedge i_core_clk) s_en = 1'b0;
        cmp8(flags, 8'h1f);
        run(`AM_SRC_IMM, `OP_AND, `TGT_F, 1'b0, 1'b0, `SK_NONE, 8'h00, 8'h00);
        regs(8'h06, 8'h10, 8'h00, 8'h08);
        cmp8({7'h00, irq_take}, 8'h00);
        @(negedge i_core_clk) s_ex = 1'b1;
        @(negedge i_core_clk) s_ex = 1'b0;
        cmp8(flags, 8'h00);
        run(`AM_NONE, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_PUSH, 8'h00, 8'h00);
        jmp = 1'b1;
        jdst = 16'h1ffd;
        run(`AM_NONE, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_CALL, 8'h00, 8'h00);
        regs(8'h06, 8'h10, 8'h03, 8'h00);
        run(`AM_SRC_IMM, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_NONE, 8'hc3, 8'h00);
        regs(8'hc3, 8'h10, 8'h03, 8'h00);
        jmp = 1'b1;
        jdst = 16'h0040;
        run(`AM_NONE, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_RET, 8'h00, 8'h00);
        run(`AM_NONE, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_POP, 8'h00, 8'h00);
        regs(8'hc3, 8'h10, 8'h00, 8'h00);
        run(`AM_SRC_IMM, `OP_ADD, `TGT_SP, 1'b0, 1'b0, `SK_ADD, 8'h21, 8'h00);
        run(`AM_NONE, `OP_MOV, `TGT_A, 1'b0, 1'b0, `SK_SWAP, 8'h00, 8'h00);
        regs(8'h21, 8'h10, 8'hc3, 8'h00);
        run(`AM_SRC_IMM, `OP_SUB, `TGT_A, 1'b0, 1'b1, `SK_NONE, 8'h22, 8'h00);
        cmp8(flags, 8'h04);
        run(`AM_SRC_IMM, `OP_XOR, `TGT_X, 1'b0, 1'b1, `SK_NONE, 8'h10, 8'h00);
        regs(8'hff, 8'h00, 8'hc3, 8'h02);
        close_out;
    end
endmodule
